// *** shared/sac_map.svh ***
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

`define SAC_ADDR_W 8
`define SAC_OFF_SC1 8'h00
`define SAC_OFF_SC2 8'h04
`define SAC_OFF_RESH 8'h08
`define SAC_OFF_RESL 8'h0C
`define SAC_OFF_CVH 8'h10
`define SAC_OFF_CVL 8'h14
`define SAC_OFF_CFG 8'h18
`define SAC_OFF_APC1 8'h1C
`define SAC_OFF_APC2 8'h20

`define SAC_CFG_LPC 7
`define SAC_CFG_DIV_HI 6
`define SAC_CFG_DIV_LO 5
`define SAC_CFG_LSMP 4
`define SAC_CFG_MODE_HI 3
`define SAC_CFG_MODE_LO 2
`define SAC_CFG_CLK_HI 1
`define SAC_CFG_CLK_LO 0

`define SAC_SC2_ACT 7
`define SAC_SC2_TRG 6
`define SAC_SC2_CFE 5
`define SAC_SC2_CFGT 4

`define SAC_SC1_DONE 7
`define SAC_SC1_IEN 6
`define SAC_SC1_CONT 5
`define SAC_SC1_CH_HI 4

`define SAC_RST_BYTE 8'h00
`define SAC_RST_CODE 12'h000
`define SAC_RESP_OK 2'h0
`define SAC_RESP_ERR 2'h2

// Sample phase in half conversion-clock cycles (3.5 and 23.5 cycles)
`define SAC_SAMPLE_SHORT_HALVES 7
`define SAC_SAMPLE_LONG_HALVES 47
// Least time rounds up to whole conversion-clock cycles
`define SAC_SAMPLE_SHORT_TICKS ((`SAC_SAMPLE_SHORT_HALVES + 1) / 2)
`define SAC_SAMPLE_LONG_TICKS ((`SAC_SAMPLE_LONG_HALVES + 1) / 2)
`define SAC_CNT_W 5

`endif

// *** shared/sac_pkg.sv ***
// Types shared by the converter control and its approximation sequencer
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_RES_8 = 2'b00,
    SAC_RES_12 = 2'b01,
    SAC_RES_10 = 2'b10,
    SAC_RES_RSV = 2'b11
  } sac_res_t;

  typedef enum logic [1:0] {
    SAC_CLK_BUS = 2'b00,
    SAC_CLK_BUSHALF = 2'b01,
    SAC_CLK_ALT = 2'b10,
    SAC_CLK_ASYNC = 2'b11
  } sac_clksrc_t;

  typedef enum logic [1:0] {
    SAC_ST_IDLE = 2'b00,
    SAC_ST_SAMPLE = 2'b01,
    SAC_ST_CONVERT = 2'b10
  } sac_state_t;
endpackage

// *** shared/sac_conv_if.sv ***
// Link between the register side and the approximation sequencer
`timescale 1ns/100ps
interface sac_conv_if;
  logic start;
  logic abort;
  logic tick;
  logic longSample;
  sac_pkg::sac_res_t resolution;
  logic compHigh;
  logic busy;
  logic done;
  logic sampleOn;
  logic [11:0] dacCode;
  logic [11:0] code;

  modport ctrl (output start, abort, tick, longSample, resolution, compHigh,
                input busy, done, sampleOn, dacCode, code);
  modport seq (input start, abort, tick, longSample, resolution, compHigh,
               output busy, done, sampleOn, dacCode, code);
endinterface

// *** src/sac_sar_seq.sv ***
// Sampling phase and successive approximation sequencer
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_sar_seq (
  input wire logic clk,
  input wire logic rst,
  sac_conv_if.seq conv
);
  import sac_pkg::*;

  sac_state_t state_reg;
  logic [`SAC_CNT_W-1:0] cnt_reg;
  logic [3:0] bitIdx_reg;
  logic [11:0] trial_reg;
  logic [11:0] topBit;
  logic [3:0] topIdx;
  logic [11:0] kept;

  always_comb begin
    unique case (conv.resolution)
      SAC_RES_12: topIdx = 4'hB;
      SAC_RES_10: topIdx = 4'h9;
      default: topIdx = 4'h7;
    endcase
    topBit = 12'h001 << topIdx;
    // Drop the trial bit when the input sits below the trial level
    kept = conv.compHigh ? trial_reg : (trial_reg & ~(12'h001 << bitIdx_reg));
  end

  always_ff @(posedge clk) begin
    conv.done <= 1'b0;
    if (rst) begin
      state_reg <= SAC_ST_IDLE;
      cnt_reg <= '0;
      bitIdx_reg <= 4'h0;
      trial_reg <= `SAC_RST_CODE;
      conv.code <= `SAC_RST_CODE;
      conv.sampleOn <= 1'b0;
    end else if (conv.start) begin
      state_reg <= SAC_ST_SAMPLE;
      conv.sampleOn <= 1'b1;
      cnt_reg <= conv.longSample ? `SAC_CNT_W'(`SAC_SAMPLE_LONG_TICKS - 1)
                                 : `SAC_CNT_W'(`SAC_SAMPLE_SHORT_TICKS - 1);
    end else if (conv.abort) begin
      state_reg <= SAC_ST_IDLE;
      conv.sampleOn <= 1'b0;
    end else if (conv.tick) begin
      unique case (state_reg)
        SAC_ST_IDLE: begin
        end
        SAC_ST_SAMPLE: begin
          if (cnt_reg == '0) begin
            state_reg <= SAC_ST_CONVERT;
            conv.sampleOn <= 1'b0;
            bitIdx_reg <= topIdx;
            trial_reg <= topBit;
          end else begin
            cnt_reg <= cnt_reg - `SAC_CNT_W'(1);
          end
        end
        SAC_ST_CONVERT: begin
          if (bitIdx_reg == 4'h0) begin
            // Input at or above the high reference keeps every bit; at or below the low one, none
            conv.code <= kept & ((topBit << 1) - 12'h001);
            conv.done <= 1'b1;
            state_reg <= SAC_ST_IDLE;
          end else begin
            bitIdx_reg <= bitIdx_reg - 4'h1;
            trial_reg <= kept | (12'h001 << (bitIdx_reg - 4'h1));
          end
        end
        default: state_reg <= SAC_ST_IDLE;
      endcase
    end
  end

  assign conv.busy = (state_reg != SAC_ST_IDLE);
  assign conv.dacCode = trial_reg;
endmodule

// *** src/sac_ctrl_top.sv ***
// Register file, conversion clock, triggering and result handling of the converter control
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_ctrl_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic deepStopEntry,
  input wire logic hwTrigger,
  input wire logic altClkTick,
  input wire logic asyncClkTick,
  input wire logic compHigh,
  output logic sampleOn,
  output logic [11:0] dacCode,
  output logic [4:0] channelSelect,
  output logic lowPowerSelect,
  output logic [15:0] pinDigitalDisable,
  output logic completeIrq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sac_pkg::*;

  sac_conv_if conv ();

  // Deepest stop mode acts as a reset of the whole block except the bus slave port, which only rst clears
  logic blockRst;
  assign blockRst = rst | deepStopEntry;

  logic [7:0] convConfig_reg;
  logic [7:0] statusControlTwo_reg;
  logic [6:0] statusControlOne_reg;
  logic doneFlag_reg;
  logic [7:0] cvHigh_reg;
  logic [7:0] cvLow_reg;
  logic [7:0] pinCtlOne_reg;
  logic [7:0] pinCtlTwo_reg;
  logic [11:0] result_reg;
  logic [7:0] lowShadow_reg;
  logic pairLocked_reg;
  logic continuing_reg;

  // Bus slave state
  logic [7:0] awAddr_reg;
  logic awHeld_reg;
  logic [7:0] wByte_reg;
  logic wByteEn_reg;
  logic wHeld_reg;
  logic doWrite;
  logic doRead;
  logic [7:0] readByte;
  logic readHit;
  logic writeHit;

  assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  assign doRead = s_axi_arvalid & s_axi_arready;

  always_comb begin
    unique case (awAddr_reg)
      `SAC_OFF_SC1, `SAC_OFF_SC2, `SAC_OFF_CVH, `SAC_OFF_CVL,
      `SAC_OFF_CFG, `SAC_OFF_APC1, `SAC_OFF_APC2: writeHit = 1'b1;
      default: writeHit = 1'b0;
    endcase
  end

  always_comb begin
    readHit = 1'b1;
    unique case (s_axi_araddr)
      `SAC_OFF_SC1: readByte = {doneFlag_reg, statusControlOne_reg};
      // Low four bits are internal use only and read back as zero
      `SAC_OFF_SC2: readByte = {conv.busy, statusControlTwo_reg[6:4], 4'h0};
      `SAC_OFF_RESH: readByte = {4'h0, result_reg[11:8]};
      `SAC_OFF_RESL: readByte = pairLocked_reg ? lowShadow_reg : result_reg[7:0];
      `SAC_OFF_CVH: readByte = cvHigh_reg;
      `SAC_OFF_CVL: readByte = cvLow_reg;
      `SAC_OFF_CFG: readByte = convConfig_reg;
      `SAC_OFF_APC1: readByte = pinCtlOne_reg;
      `SAC_OFF_APC2: readByte = pinCtlTwo_reg;
      default: begin
        readByte = `SAC_RST_BYTE;
        readHit = 1'b0;
      end
    endcase
  end

  // Write address channel
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      awHeld_reg <= 1'b0;
      awAddr_reg <= `SAC_RST_BYTE;
    end else if (s_axi_awvalid & s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awHeld_reg <= 1'b1;
      awAddr_reg <= {s_axi_awaddr[7:2], 2'b00};
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end else if (!awHeld_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel; registers are one byte wide, so only lane 0 matters
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      wHeld_reg <= 1'b0;
      wByte_reg <= `SAC_RST_BYTE;
      wByteEn_reg <= 1'b0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wHeld_reg <= 1'b1;
      wByte_reg <= s_axi_wdata[7:0];
      wByteEn_reg <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end else if (!wHeld_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAC_RESP_OK;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writeHit ? `SAC_RESP_OK : `SAC_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data leaves one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SAC_RESP_OK;
    end else if (doRead) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, readByte};
      s_axi_rresp <= readHit ? `SAC_RESP_OK : `SAC_RESP_ERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  logic wrStrobe;
  logic wrSc1;
  assign wrStrobe = doWrite & wByteEn_reg;
  assign wrSc1 = wrStrobe & (awAddr_reg == `SAC_OFF_SC1);

  // Software-writable configuration
  always_ff @(posedge clk) begin
    if (blockRst) begin
      convConfig_reg <= `SAC_RST_BYTE;
      statusControlTwo_reg <= `SAC_RST_BYTE;
      statusControlOne_reg <= 7'h00;
      cvHigh_reg <= `SAC_RST_BYTE;
      cvLow_reg <= `SAC_RST_BYTE;
      pinCtlOne_reg <= `SAC_RST_BYTE;
      pinCtlTwo_reg <= `SAC_RST_BYTE;
    end else if (wrStrobe) begin
      unique case (awAddr_reg)
        `SAC_OFF_CFG: convConfig_reg <= wByte_reg;
        // Busy flag is read-only; reserved bits are not stored
        `SAC_OFF_SC2: statusControlTwo_reg <= {1'b0, wByte_reg[6:4], 4'h0};
        `SAC_OFF_SC1: statusControlOne_reg <= wByte_reg[6:0];
        `SAC_OFF_CVH: cvHigh_reg <= wByte_reg;
        `SAC_OFF_CVL: cvLow_reg <= wByte_reg;
        `SAC_OFF_APC1: pinCtlOne_reg <= wByte_reg;
        `SAC_OFF_APC2: pinCtlTwo_reg <= wByte_reg;
        default: begin
        end
      endcase
    end
  end

  // Conversion clock: source select, then divide by 1, 2, 4 or 8
  logic busHalf_reg;
  logic srcTick;
  logic [2:0] divCnt_reg;
  logic [2:0] divLimit;
  sac_clksrc_t clkSrc;
  assign clkSrc = sac_clksrc_t'(convConfig_reg[`SAC_CFG_CLK_HI:`SAC_CFG_CLK_LO]);
  assign divLimit = 3'((4'h1 << convConfig_reg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO]) - 4'h1);

  always_comb begin
    unique case (clkSrc)
      SAC_CLK_BUS: srcTick = 1'b1;
      SAC_CLK_BUSHALF: srcTick = busHalf_reg;
      SAC_CLK_ALT: srcTick = altClkTick;
      SAC_CLK_ASYNC: srcTick = asyncClkTick;
    endcase
  end

  always_ff @(posedge clk) begin
    if (blockRst) begin
      busHalf_reg <= 1'b0;
    end else begin
      busHalf_reg <= ~busHalf_reg;
    end
  end

  always_ff @(posedge clk) begin
    conv.tick <= 1'b0;
    if (blockRst) begin
      divCnt_reg <= 3'h0;
    end else if (conv.start) begin
      // Start edge counts as the first source tick, else sampling grows by one bus cycle
      divCnt_reg <= (srcTick && divLimit != 3'h0) ? 3'h1 : 3'h0;
      conv.tick <= srcTick && (divLimit == 3'h0);
    end else if (srcTick) begin
      if (divCnt_reg >= divLimit) begin
        divCnt_reg <= 3'h0;
        conv.tick <= 1'b1;
      end else begin
        divCnt_reg <= divCnt_reg + 3'h1;
      end
    end
  end

  // Triggering
  logic swTrigSel;
  logic hwStart;
  assign swTrigSel = ~statusControlTwo_reg[`SAC_SC2_TRG];
  assign hwStart = ~swTrigSel & hwTrigger & ~conv.busy;

  always_ff @(posedge clk) begin
    if (blockRst) begin
      conv.start <= 1'b0;
      conv.abort <= 1'b0;
      continuing_reg <= 1'b0;
    end else begin
      // A control-one write always abandons the running conversion
      conv.abort <= wrSc1;
      conv.start <= (wrSc1 & swTrigSel) | hwStart | (continuing_reg & ~wrSc1);
      continuing_reg <= conv.done & statusControlOne_reg[`SAC_SC1_CONT] & ~wrSc1;
    end
  end

  assign conv.longSample = convConfig_reg[`SAC_CFG_LSMP];
  assign conv.resolution = sac_res_t'(convConfig_reg[`SAC_CFG_MODE_HI:`SAC_CFG_MODE_LO]);
  assign conv.compHigh = compHigh;

  // Compare: difference against the compare value; direction picks the limit
  logic [11:0] cmpValue;
  logic [11:0] cmpDiff;
  logic cmpPass;
  logic cmpEnable;
  assign cmpValue = {cvHigh_reg[3:0], cvLow_reg};
  assign cmpDiff = conv.code - cmpValue;
  assign cmpEnable = statusControlTwo_reg[`SAC_SC2_CFE];
  assign cmpPass = statusControlTwo_reg[`SAC_SC2_CFGT] ? (conv.code >= cmpValue)
                                                       : (conv.code < cmpValue);

  logic accept;
  logic readLow;
  logic readHigh;
  assign accept = conv.done & (~cmpEnable | cmpPass);
  assign readHigh = doRead & (s_axi_araddr == `SAC_OFF_RESH);
  assign readLow = doRead & (s_axi_araddr == `SAC_OFF_RESL);

  always_ff @(posedge clk) begin
    if (blockRst) begin
      result_reg <= `SAC_RST_CODE;
    end else if (accept) begin
      result_reg <= cmpEnable ? cmpDiff : conv.code;
    end
  end

  // High read freezes the low byte so a finishing conversion cannot split the pair
  always_ff @(posedge clk) begin
    if (blockRst) begin
      pairLocked_reg <= 1'b0;
      lowShadow_reg <= `SAC_RST_BYTE;
    end else if (readHigh) begin
      pairLocked_reg <= 1'b1;
      lowShadow_reg <= result_reg[7:0];
    end else if (readLow) begin
      pairLocked_reg <= 1'b0;
    end
  end

  // Completion flag: a new completion wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (blockRst) begin
      doneFlag_reg <= 1'b0;
    end else if (accept) begin
      doneFlag_reg <= 1'b1;
    end else if (wrSc1 || readLow) begin
      doneFlag_reg <= 1'b0;
    end
  end

  // Outputs to the analog side and pads, all registered
  always_ff @(posedge clk) begin
    if (blockRst) begin
      completeIrq <= 1'b0;
      lowPowerSelect <= 1'b0;
      channelSelect <= 5'h00;
      pinDigitalDisable <= 16'h0000;
      sampleOn <= 1'b0;
      dacCode <= `SAC_RST_CODE;
    end else begin
      completeIrq <= doneFlag_reg & statusControlOne_reg[`SAC_SC1_IEN];
      lowPowerSelect <= convConfig_reg[`SAC_CFG_LPC];
      channelSelect <= statusControlOne_reg[`SAC_SC1_CH_HI:0];
      // Pin control only affects the pads; conversion never looks at it
      pinDigitalDisable <= {pinCtlTwo_reg, pinCtlOne_reg};
      sampleOn <= conv.sampleOn;
      dacCode <= conv.dacCode;
    end
  end

  sac_sar_seq u_seq (
    .clk(clk),
    .rst(blockRst),
    .conv(conv.seq)
  );
endmodule

// *** sim/sac_ctrl_asserts.sv ***
// Port-level checks of the converter control top
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic deepStopEntry,
  input wire logic sampleOn,
  input wire logic [11:0] dacCode,
  input wire logic [4:0] channelSelect,
  input wire logic lowPowerSelect,
  input wire logic [15:0] pinDigitalDisable,
  input wire logic completeIrq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [7:0] wrAddrReg;
  logic [7:0] wrDataReg;
  logic wrStrbReg;
  logic [5:0] sampleCntReg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Address and data may be taken on different edges, so each is kept on its own handshake
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wrAddrReg <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wrDataReg <= s_axi_wdata[7:0];
      wrStrbReg <= s_axi_wstrb[0];
    end
  end
  // Saturates so that long divided sampling cannot wrap
  always_ff @(posedge clk) begin
    if (rst || deepStopEntry || !sampleOn) begin
      sampleCntReg <= 6'h00;
    end else if (sampleCntReg != 6'h3F) begin
      sampleCntReg <= sampleCntReg + 6'h01;
    end
  end
  sequence s_wr_ok;
    $rose(s_axi_bvalid) && s_axi_bresp == `SAC_RESP_OK && wrStrbReg;
  endsequence
  property p_stop_out;
    deepStopEntry |=> !sampleOn && dacCode == `SAC_RST_CODE && !completeIrq;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("outputs active after deep stop");
  property p_stop_regs;
    $fell(deepStopEntry) |-> channelSelect == 5'h00 && !lowPowerSelect && pinDigitalDisable == 16'h0000;
  endproperty
  a_stop_regs: assert property (p_stop_regs) else $error("registers kept after deep stop");
  property p_low_power;
    disable iff (rst || deepStopEntry) s_wr_ok ##0 wrAddrReg == `SAC_OFF_CFG |-> ##[0:2] lowPowerSelect == wrDataReg[7];
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power select not updated");
  property p_channel;
    disable iff (rst || deepStopEntry) s_wr_ok ##0 wrAddrReg == `SAC_OFF_SC1 |-> ##[0:2] channelSelect == wrDataReg[4:0];
  endproperty
  a_channel: assert property (p_channel) else $error("channel select not updated");
  property p_pins;
    disable iff (rst || deepStopEntry)
      s_wr_ok ##0 wrAddrReg == `SAC_OFF_APC1 |-> ##[0:2] pinDigitalDisable[7:0] == wrDataReg;
  endproperty
  a_pins: assert property (p_pins) else $error("pin control not updated");
  property p_sample_len;
    disable iff (rst || deepStopEntry) $fell(sampleOn) |-> sampleCntReg >= `SAC_SAMPLE_SHORT_TICKS;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling phase too short");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response held after handshake");
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read data late");
  c_sample: cover property ($rose(sampleOn));
  c_irq: cover property ($rose(completeIrq));
  c_stop: cover property ($fell(deepStopEntry));
endmodule

bind sac_ctrl_top sac_ctrl_asserts u_chk (.clk, .rst, .deepStopEntry, .sampleOn, .dacCode, .channelSelect,
  .lowPowerSelect, .pinDigitalDisable, .completeIrq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// *** sim/sac_analog_src.sv ***
// Analog source on the selected input, seen through the comparator
`timescale 1ns/100ps
module sac_analog_src (
  input wire logic [11:0] dacCode,
  input wire logic inputHigh,
  output logic compHigh
);
  // Input pinned at a reference; every input is at or above a zero trial code
  always_comb begin
    compHigh = inputHigh || dacCode == 12'h000;
  end
endmodule

// *** sim/sac_ctrl_top_tb.sv ***
// Register-level tests of the converter control
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_ctrl_top_tb;
  logic clk, rst, deepStopEntry, hwTrigger, altClkTick, asyncClkTick, compHigh, inputHigh;
  logic sampleOn, completeIrq, lowPowerSelect;
  logic [11:0] dacCode;
  logic [4:0] channelSelect;
  logic [15:0] pinDigitalDisable;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rd, lastRun, runLen;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int mismatches = 0;
  int checksDone = 0;
  logic [7:0] regMap [9] = '{`SAC_OFF_SC1, `SAC_OFF_SC2, `SAC_OFF_RESH, `SAC_OFF_RESL, `SAC_OFF_CVH,
    `SAC_OFF_CVL, `SAC_OFF_CFG, `SAC_OFF_APC1, `SAC_OFF_APC2};
  // Config, input level, sample cycles, result high and low per conversion
  logic [7:0] cfgTab [6] = '{8'h00, 8'h10, 8'h20, 8'h64, 8'h08, 8'h04};
  logic lvlTab [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] runTab [6] = '{8'h04, 8'h18, 8'h08, 8'h20, 8'h04, 8'h04};
  logic [7:0] hiTab [6] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h03, 8'h00};
  logic [7:0] loTab [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  sac_ctrl_top dut (.clk, .rst, .deepStopEntry, .hwTrigger, .altClkTick, .asyncClkTick, .compHigh, .sampleOn,
    .dacCode, .channelSelect, .lowPowerSelect, .pinDigitalDisable, .completeIrq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  sac_analog_src src (.dacCode, .inputHigh, .compHigh);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    altClkTick <= ~altClkTick;
    asyncClkTick <= altClkTick;
  end
  // Length of the last sampling phase, measured independently of the bus traffic
  always @(posedge clk) begin
    if (sampleOn === 1'b1) begin
      runLen <= runLen + 8'h01;
    end else if (runLen != 8'h00) begin
      lastRun <= runLen;
      runLen <= 8'h00;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aDone, wDone;
    aDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic expectReg(input string what, input logic [7:0] a, input logic [7:0] exp);
    rdReg(a);
    chk(what, rd, exp);
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    do begin
      rdReg(`SAC_OFF_SC1);
      n++;
    end while (rd[7] !== 1'b1 && n < 300);
    chk("complete flag", rd[7], 1'b1);
  endtask
  task automatic endSim();
    if (mismatches == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    endSim();
  end

  initial begin
    rst = 1'b1;
    {deepStopEntry, hwTrigger, altClkTick, asyncClkTick, lastRun, runLen} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    inputHigh = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (regMap[i]) expectReg("reset value", regMap[i], 8'h00);
    rdReg(8'h24);
    chk("unmapped read", rsp, `SAC_RESP_ERR);
    wr(8'h24, 8'h5A);
    chk("unmapped write", rsp, `SAC_RESP_ERR);
    wr(`SAC_OFF_CFG, 8'h98);
    expectReg("config", `SAC_OFF_CFG, 8'h98);
    chk("low power", lowPowerSelect, 1'b1);
    wr(`SAC_OFF_SC2, 8'h30);
    expectReg("control two", `SAC_OFF_SC2, 8'h30);
    wr(`SAC_OFF_SC2, 8'h00);
    wr(`SAC_OFF_APC1, 8'h02);
    wr(`SAC_OFF_APC2, 8'h80);
    // Pad outputs follow the register one edge after the write response
    @(posedge clk);
    chk("pin disable", pinDigitalDisable, 16'h8002);
    foreach (cfgTab[i]) begin
      inputHigh = lvlTab[i];
      wr(`SAC_OFF_CFG, cfgTab[i]);
      wr(`SAC_OFF_SC1, 8'h41);
      expectReg("busy", `SAC_OFF_SC2, 8'h80);
      waitDone();
      chk("sample cycles", lastRun, runTab[i]);
      chk("irq", completeIrq, 1'b1);
      expectReg("result high", `SAC_OFF_RESH, hiTab[i]);
      expectReg("result low", `SAC_OFF_RESL, loTab[i]);
    end
    inputHigh = 1'b1;
    wr(`SAC_OFF_SC1, 8'h01);
    waitDone();
    chk("irq masked", completeIrq, 1'b0);
    expectReg("result high", `SAC_OFF_RESH, 8'h0F);
    inputHigh = 1'b0;
    wr(`SAC_OFF_SC1, 8'h01);
    waitDone();
    expectReg("frozen low", `SAC_OFF_RESL, 8'hFF);
    expectReg("result high", `SAC_OFF_RESH, 8'h00);
    expectReg("result low", `SAC_OFF_RESL, 8'h00);
    wr(`SAC_OFF_CVH, 8'h08);
    wr(`SAC_OFF_SC2, 8'h30);
    wr(`SAC_OFF_SC1, 8'h01);
    repeat (150) @(posedge clk);
    expectReg("compare miss", `SAC_OFF_SC1, 8'h01);
    wr(`SAC_OFF_SC2, 8'h20);
    wr(`SAC_OFF_SC1, 8'h01);
    waitDone();
    expectReg("compare high", `SAC_OFF_RESH, 8'h08);
    expectReg("compare low", `SAC_OFF_RESL, 8'h00);
    inputHigh = 1'b1;
    wr(`SAC_OFF_SC2, 8'h40);
    wr(`SAC_OFF_SC1, 8'h01);
    @(posedge clk);
    hwTrigger <= 1'b1;
    @(posedge clk);
    hwTrigger <= 1'b0;
    waitDone();
    expectReg("hw result", `SAC_OFF_RESH, 8'h0F);
    wr(`SAC_OFF_SC2, 8'h00);
    wr(`SAC_OFF_CFG, 8'h03);
    wr(`SAC_OFF_SC1, 8'h01);
    waitDone();
    expectReg("async clock", `SAC_OFF_RESH, 8'h00);
    wr(`SAC_OFF_CFG, 8'h14);
    wr(`SAC_OFF_SC1, 8'h01);
    // Lands in the approximation phase, after the long sample
    repeat (30) @(posedge clk);
    wr(`SAC_OFF_SC1, 8'h02);
    waitDone();
    chk("channel", channelSelect, 16'h0002);
    chk("long sample", lastRun, 8'h18);
    wr(`SAC_OFF_CFG, 8'h80);
    wr(`SAC_OFF_SC1, 8'h21);
    waitDone();
    rdReg(`SAC_OFF_RESL);
    waitDone();
    @(posedge clk);
    deepStopEntry <= 1'b1;
    repeat (3) @(posedge clk);
    deepStopEntry <= 1'b0;
    @(posedge clk);
    chk("sampling off", sampleOn, 1'b0);
    chk("low power", lowPowerSelect, 1'b0);
    expectReg("config", `SAC_OFF_CFG, 8'h00);
    expectReg("control one", `SAC_OFF_SC1, 8'h00);
    endSim();
  end
endmodule
